// ### common/dcs_pkg.sv
// shared constants and carriers for the disk command sequencer
// assumes a 25 MHz core clock; drive pins arrive unsynchronised
package dcs_pkg;

  localparam int CLK_MHZ           = 25;
  localparam int T_RATE0_NS        = 10_000;
  localparam int T_STEP_UNIT_NS    = 500_000;
  localparam int T_STEP_PW_NS      = 1_000;
  localparam int RATE0_CYC         = (T_RATE0_NS * CLK_MHZ) / 1000;
  localparam int STEP_UNIT_CYC     = (T_STEP_UNIT_NS * CLK_MHZ) / 1000;
  localparam int STEP_PW_CYC       = (T_STEP_PW_NS * CLK_MHZ + 999) / 1000;
  localparam int MAX_TRIES         = 16;
  localparam int MAX_RESTORE_STEPS = 1023;
  localparam int SETTLE_INDEX      = 128;

  // task file addresses; 1 and 7 differ between read and write
  localparam logic [2:0] A_DATA   = 3'h0;
  localparam logic [2:0] A_ERROR  = 3'h1;
  localparam logic [2:0] A_SCOUNT = 3'h2;
  localparam logic [2:0] A_SNUM   = 3'h3;
  localparam logic [2:0] A_CYL_LO = 3'h4;
  localparam logic [2:0] A_CYL_HI = 3'h5;
  localparam logic [2:0] A_SDH    = 3'h6;
  localparam logic [2:0] A_CMD    = 3'h7;

  localparam int ST_BUSY    = 7;
  localparam int ST_READY   = 6;
  localparam int ST_WFAULT  = 5;
  localparam int ST_SEEKOK  = 4;
  localparam int ST_DREQ    = 3;
  localparam int ST_ERROR   = 0;

  localparam int E_BADBLK   = 7;
  localparam int E_DCRC     = 6;
  localparam int E_IDCRC    = 5;
  localparam int E_IDNF     = 4;
  localparam int E_ABORT    = 2;
  localparam int E_TRK0     = 1;
  localparam int E_MARK     = 0;

  localparam logic [3:0] OP_RESTORE = 4'h1;
  localparam logic [3:0] OP_SEEK    = 4'h7;
  localparam logic [3:0] OP_READ    = 4'h2;
  localparam logic [3:0] OP_WRITE   = 4'h3;
  localparam logic [3:0] OP_FORMAT  = 4'h5;
  localparam int         OP_MSB     = 7;
  localparam int         OP_LSB     = 4;
  localparam int         CMD_DMA    = 3;

  localparam logic [3:0] RATE_RST    = 4'hf;
  localparam logic [7:0] PRECOMP_RST = 8'h20;
  localparam logic [7:0] SCOUNT_RST  = 8'h01;

  localparam int         SDH_SZ_MSB  = 6;
  localparam int         SDH_SZ_LSB  = 5;
  localparam int         SDH_DRV_MSB = 4;
  localparam int         SDH_DRV_LSB = 3;
  localparam int         SDH_HD_MSB  = 2;
  localparam int         SDH_HD_LSB  = 0;
  localparam logic [1:0] SZ_128      = 2'h3;
  localparam logic [1:0] SZ_512      = 2'h1;
  localparam logic [8:0] LAST_128    = 9'h07f;
  localparam logic [8:0] LAST_256    = 9'h0ff;
  localparam logic [8:0] LAST_512    = 9'h1ff;

  localparam int BUF_AW    = 9;
  localparam int BUF_DEPTH = 512;

  typedef enum logic [8:0] {
    S_IDLE   = 9'h001,
    S_FILL   = 9'h002,
    S_CHECK  = 9'h004,
    S_STEP   = 9'h008,
    S_SETTLE = 9'h010,
    S_TRY    = 9'h020,
    S_WAIT   = 9'h040,
    S_XFER   = 9'h080,
    S_WDISK  = 9'h100
  } dcs_state_e;

  typedef enum logic [2:0] {
    RES_OK      = 3'h0,
    RES_NO_ID   = 3'h1,
    RES_ID_CRC  = 3'h2,
    RES_NO_MARK = 3'h3,
    RES_D_CRC   = 3'h4,
    RES_BAD_BLK = 3'h5
  } dcs_res_e;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } dcs_host_s;

  typedef struct packed {
    logic seek_done;
    logic ready;
    logic write_fault;
    logic track_zero_input;
    logic index;
  } dcs_drv_in_s;

  typedef struct packed {
    logic       step;
    logic       dir_out;
    logic       write_gate;
    logic       reduce_current;
    logic [3:0] dsel;
    logic [2:0] head;
  } dcs_drv_out_s;

  typedef struct packed {
    logic       res_v;
    dcs_res_e   res;
    logic       rbyte_v;
    logic [7:0] rbyte;
  } dcs_chan_in_s;

  typedef struct packed {
    logic       search;
    logic       wbyte_v;
    logic [7:0] wbyte;
  } dcs_chan_out_s;

endpackage

// ### src/dcs_sector_ram.sv
// sector buffer: one write port, one read port with registered data
// assumes the caller presents next-cycle read addresses
`timescale 1ns/1ps
module dcs_sector_ram (
  input  wire logic                       clk_i,
  input  wire logic                       we_i,
  input  wire logic [dcs_pkg::BUF_AW-1:0] waddr_i,
  input  wire logic [7:0]                 wdata_i,
  input  wire logic [dcs_pkg::BUF_AW-1:0] raddr_i,
  output logic      [7:0]                 rdata_o
);
  // no reset so the array maps onto block ram
  logic [7:0] mem [dcs_pkg::BUF_DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

// ### src/dcs_sequencer.sv
// disk command sequencer: task file, command decode, stepping, retries
// assumes host strobes and channel results on clk_i, drive pins async
// Functional notes
// - refuse commands unless seek-complete, ready, no fault
// - command high nibble selects the operation
// - step period 10 us or code times 0.5 ms
// - restore and seek save step rate
// - dma flag places interrupt before or after transfer
// - restore sets busy, clears cylinder registers
// - failed check aborts with interrupt, busy cleared
// - restore steps outward until track zero
// - no track zero in 1023 steps: error
// - seek steps per cylinder, interrupts without waiting
// - read check failure simulates normal completion
// - implied seek times out after 128 index pulses
// - read retries up to 16 attempts
// - errors logged; id misses trigger auto-restore
// - at most one auto-restore per command
// - unrecoverable error reports worst logged bit
// - write sector requests each buffer byte first
// - busy and drive check only after fill
// - write retries id search up to 16 times
// - interrupt clears on status read or command
// - data request clears on data register access
// - status and error bit layout
// - direction high steps outward
`timescale 1ns/1ps
module dcs_sequencer #(
  parameter int STEP_UNIT_CYC = dcs_pkg::STEP_UNIT_CYC
) (
  input  wire logic                   clk_i,
  input  wire logic                   arst_n_i,
  input  wire dcs_pkg::dcs_host_s     host_i,
  output logic [7:0]                  host_rdata_o,
  output logic                        interrupt_request_out_o,
  output logic                        data_request_out_o,
  input  wire dcs_pkg::dcs_drv_in_s   drv_i,
  output dcs_pkg::dcs_drv_out_s       drv_o,
  input  wire dcs_pkg::dcs_chan_in_s  chan_i,
  output dcs_pkg::dcs_chan_out_s      chan_o
);

  typedef struct packed {
    dcs_pkg::dcs_state_e    state;
    logic [7:0]             cmd;
    logic [3:0]             rate;
    logic [7:0]             precomp;
    logic [7:0]             scount;
    logic [7:0]             snum;
    logic [7:0]             cyl_lo;
    logic [7:0]             cyl_hi;
    logic [7:0]             sdh;
    logic [3:0][9:0]        hpos;
    logic                   busy;
    logic                   err;
    logic [7:0]             errreg;
    logic [7:0]             hist;
    logic                   irq;
    logic                   dreq;
    logic [7:0]             rdata;
    dcs_pkg::dcs_drv_out_s  po;
    dcs_pkg::dcs_chan_out_s co;
    logic [17:0]            tmr;
    logic [9:0]             nstep;
    logic [7:0]             idxc;
    logic [3:0]             tries;
    logic                   ar_used;
    logic                   autor;
    logic                   restoring;
    logic [8:0]             bptr;
    dcs_pkg::dcs_drv_in_s   s1;
    dcs_pkg::dcs_drv_in_s   s2;
    logic                   idx_d;
  } dcs_regs_s;

  localparam logic [17:0] TMR_MAX = 18'h3ffff;

  dcs_regs_s             r;
  dcs_regs_s             n;
  dcs_pkg::dcs_drv_in_s  drv;
  logic                  idx_rise;
  logic                  drive_ok;
  logic [8:0]            last;
  logic [17:0]           period;
  logic                  step_ready;
  logic [9:0]            cyl;
  logic [1:0]            dsel;
  logic [3:0]            op;
  logic                  is_read;
  logic [7:0]            q;
  logic                  ram_we;
  logic [8:0]            ram_waddr;
  logic [7:0]            ram_wdata;
  logic                  do_seek;
  logic                  fin;
  logic                  data_rd;
  logic                  data_wr;
  logic                  cyl_lo_hit;
  logic [7:0]            status;

  function automatic logic [7:0] dcs_worst(input logic [7:0] h);
    logic [7:0] o;
    o = '0;
    for (int i = 0; i < 8; i++) begin
      if (h[i]) begin
        o = 8'h01 << i;
      end
    end
    return o;
  endfunction

  assign drv        = r.s2;
  assign idx_rise   = drv.index & ~r.idx_d;
  assign drive_ok   = drv.seek_done & drv.ready & ~drv.write_fault;
  assign cyl        = {r.cyl_hi[1:0], r.cyl_lo};
  assign dsel       = r.sdh[dcs_pkg::SDH_DRV_MSB:dcs_pkg::SDH_DRV_LSB];
  assign op         = r.cmd[dcs_pkg::OP_MSB:dcs_pkg::OP_LSB];
  assign is_read    = (op == dcs_pkg::OP_READ);
  assign data_rd    = host_i.rd && host_i.addr == dcs_pkg::A_DATA;
  assign data_wr    = host_i.wr && host_i.addr == dcs_pkg::A_DATA;
  assign cyl_lo_hit = (host_i.rd || host_i.wr) && host_i.addr == dcs_pkg::A_CYL_LO;
  assign period     = (r.rate == 4'h0) ? 18'(dcs_pkg::RATE0_CYC)
                                       : 18'(r.rate) * 18'(STEP_UNIT_CYC);
  // auto-restore paces on seek complete, with the shortest period as a floor
  assign step_ready = r.autor ? (r.tmr >= 18'(dcs_pkg::RATE0_CYC) && drv.seek_done)
                              : (r.tmr >= period);

  always_comb begin
    unique case (r.sdh[dcs_pkg::SDH_SZ_MSB:dcs_pkg::SDH_SZ_LSB])
      dcs_pkg::SZ_128: last = dcs_pkg::LAST_128;
      dcs_pkg::SZ_512: last = dcs_pkg::LAST_512;
      default:         last = dcs_pkg::LAST_256;
    endcase
  end

  always_comb begin
    status                   = '0;
    status[dcs_pkg::ST_BUSY]   = r.busy;
    status[dcs_pkg::ST_READY]  = drv.ready;
    status[dcs_pkg::ST_WFAULT] = drv.write_fault;
    status[dcs_pkg::ST_SEEKOK] = drv.seek_done;
    status[dcs_pkg::ST_DREQ]   = r.dreq;
    status[dcs_pkg::ST_ERROR]  = r.err;
  end

  always_comb begin
    n            = r;
    n.s1         = drv_i;
    n.s2         = r.s1;
    n.idx_d      = r.s2.index;
    n.rdata      = '0;
    n.co.search  = 1'b0;
    n.co.wbyte_v = 1'b0;
    n.po.write_gate = 1'b0;
    ram_we       = 1'b0;
    ram_waddr    = r.bptr;
    ram_wdata    = host_i.wdata;
    do_seek      = 1'b0;
    fin          = 1'b0;

    // host reads; the status read clear comes first so a completion wins
    if (host_i.rd) begin
      unique case (host_i.addr)
        dcs_pkg::A_DATA:   n.rdata = q;
        dcs_pkg::A_ERROR:  n.rdata = r.errreg;
        dcs_pkg::A_SCOUNT: n.rdata = r.scount;
        dcs_pkg::A_SNUM:   n.rdata = r.snum;
        dcs_pkg::A_CYL_LO: n.rdata = r.cyl_lo;
        dcs_pkg::A_CYL_HI: n.rdata = r.cyl_hi;
        dcs_pkg::A_SDH:    n.rdata = r.sdh;
        dcs_pkg::A_CMD: begin
          n.rdata = status;
          n.irq   = 1'b0;
        end
      endcase
    end
    if (host_i.wr) begin
      unique case (host_i.addr)
        dcs_pkg::A_ERROR:  n.precomp = host_i.wdata;
        dcs_pkg::A_SCOUNT: n.scount  = host_i.wdata;
        dcs_pkg::A_SNUM:   n.snum    = host_i.wdata;
        dcs_pkg::A_CYL_LO: n.cyl_lo  = host_i.wdata;
        dcs_pkg::A_CYL_HI: n.cyl_hi  = host_i.wdata;
        dcs_pkg::A_SDH:    n.sdh     = host_i.wdata;
        default: ;
      endcase
    end

    unique case (r.state)
      dcs_pkg::S_IDLE: ;
      dcs_pkg::S_FILL: begin
        if (data_wr) begin
          ram_we = 1'b1;
          n.dreq = 1'b0;
          n.bptr = r.bptr + 9'h001;
        end else begin
          n.dreq = !data_rd;
        end
        if ((data_wr && r.bptr == last) || cyl_lo_hit) begin
          n.dreq  = 1'b0;
          n.busy  = 1'b1;
          n.bptr  = '0;
          n.state = dcs_pkg::S_CHECK;
        end
      end
      dcs_pkg::S_CHECK: begin
        if (!drive_ok) begin
          n.errreg[dcs_pkg::E_ABORT] = 1'b1;
          n.err = 1'b1;
          fin   = 1'b1;
        end else if (op == dcs_pkg::OP_RESTORE) begin
          n.hpos[dsel] = '0;
          n.restoring  = 1'b1;
          n.nstep      = '0;
          n.tmr        = TMR_MAX;
          n.state      = dcs_pkg::S_STEP;
        end else if (op == dcs_pkg::OP_FORMAT) begin
          fin = 1'b1;
        end else begin
          do_seek = 1'b1;
        end
      end
      dcs_pkg::S_STEP: begin
        if (r.tmr < period) begin
          n.tmr = r.tmr + 18'h00001;
        end
        if (r.tmr == 18'(dcs_pkg::STEP_PW_CYC - 1)) begin
          n.po.step = 1'b0;
        end
        if (step_ready) begin
          if (r.restoring) begin
            if (drv.track_zero_input) begin
              if (r.autor) begin
                n.autor = 1'b0;
                do_seek = 1'b1;
              end else begin
                fin = 1'b1;
              end
            end else if (r.nstep == 10'(dcs_pkg::MAX_RESTORE_STEPS)) begin
              n.errreg[dcs_pkg::E_TRK0] = 1'b1;
              n.err = 1'b1;
              fin   = 1'b1;
            end else begin
              n.po.step    = 1'b1;
              n.po.dir_out = 1'b1;
              n.tmr        = '0;
              n.nstep      = r.nstep + 10'h001;
            end
          end else if (r.nstep == 10'h000) begin
            if (op == dcs_pkg::OP_SEEK) begin
              fin = 1'b1;
            end else begin
              n.idxc  = '0;
              n.state = dcs_pkg::S_SETTLE;
            end
          end else begin
            n.po.step = 1'b1;
            n.tmr     = '0;
            n.nstep   = r.nstep - 10'h001;
          end
        end
      end
      dcs_pkg::S_SETTLE: begin
        if (drv.seek_done) begin
          n.tries = '0;
          n.state = dcs_pkg::S_TRY;
        end else if (idx_rise) begin
          if (r.idxc == 8'(dcs_pkg::SETTLE_INDEX - 1)) begin
            n.errreg[dcs_pkg::E_ABORT] = 1'b1;
            n.err = 1'b1;
            fin   = 1'b1;
          end else begin
            n.idxc = r.idxc + 8'h01;
          end
        end
      end
      dcs_pkg::S_TRY: begin
        n.co.search = 1'b1;
        n.bptr      = '0;
        n.state     = dcs_pkg::S_WAIT;
      end
      dcs_pkg::S_WAIT: begin
        if (is_read && chan_i.rbyte_v) begin
          ram_we    = 1'b1;
          ram_wdata = chan_i.rbyte;
          n.bptr    = r.bptr + 9'h001;
        end
        if (chan_i.res_v) begin
          unique case (chan_i.res)
            dcs_pkg::RES_OK: begin
              if (is_read) begin
                fin = 1'b1;
              end else begin
                n.bptr  = '0;
                n.state = dcs_pkg::S_WDISK;
              end
            end
            dcs_pkg::RES_BAD_BLK: begin
              n.errreg = 8'h01 << dcs_pkg::E_BADBLK;
              n.err    = 1'b1;
              fin      = 1'b1;
            end
            default: begin
              unique case (chan_i.res)
                dcs_pkg::RES_NO_ID:   n.hist[dcs_pkg::E_IDNF]  = 1'b1;
                dcs_pkg::RES_ID_CRC:  n.hist[dcs_pkg::E_IDCRC] = 1'b1;
                dcs_pkg::RES_NO_MARK: n.hist[dcs_pkg::E_MARK]  = 1'b1;
                default:              n.hist[dcs_pkg::E_DCRC]  = 1'b1;
              endcase
              if (r.tries != 4'(dcs_pkg::MAX_TRIES - 1)) begin
                n.tries = r.tries + 4'h1;
                n.state = dcs_pkg::S_TRY;
              end else if ((chan_i.res == dcs_pkg::RES_NO_ID ||
                            chan_i.res == dcs_pkg::RES_ID_CRC) && !r.ar_used) begin
                n.ar_used    = 1'b1;
                n.autor      = 1'b1;
                n.restoring  = 1'b1;
                n.hpos[dsel] = '0;
                n.nstep      = '0;
                n.tmr        = TMR_MAX;
                n.state      = dcs_pkg::S_STEP;
              end else begin
                n.errreg = r.errreg | dcs_worst(n.hist);
                n.err    = 1'b1;
                fin      = 1'b1;
              end
            end
          endcase
        end
      end
      dcs_pkg::S_XFER: begin
        if (data_rd) begin
          n.dreq = 1'b0;
          n.bptr = r.bptr + 9'h001;
          if (r.bptr == last) begin
            n.irq   = r.cmd[dcs_pkg::CMD_DMA];
            n.state = dcs_pkg::S_IDLE;
          end
        end else begin
          n.dreq = !data_wr;
        end
        if (cyl_lo_hit) begin
          n.dreq  = 1'b0;
          n.state = dcs_pkg::S_IDLE;
        end
      end
      dcs_pkg::S_WDISK: begin
        n.po.write_gate = 1'b1;
        n.co.wbyte_v    = 1'b1;
        n.co.wbyte      = q;
        n.bptr          = r.bptr + 9'h001;
        if (r.bptr == last) begin
          fin = 1'b1;
        end
      end
    endcase

    if (do_seek) begin
      n.restoring = 1'b0;
      n.tmr       = TMR_MAX;
      n.hpos[dsel] = cyl;
      n.state     = dcs_pkg::S_STEP;
      if (cyl < r.hpos[dsel]) begin
        n.po.dir_out = 1'b1;
        n.nstep      = r.hpos[dsel] - cyl;
      end else begin
        n.po.dir_out = 1'b0;
        n.nstep      = cyl - r.hpos[dsel];
      end
    end

    if (fin) begin
      n.busy = 1'b0;
      n.bptr = '0;
      if (is_read) begin
        // read always ends in a transfer, even after an error
        n.state = dcs_pkg::S_XFER;
        n.dreq  = 1'b0;
        n.irq   = ~r.cmd[dcs_pkg::CMD_DMA];
      end else begin
        n.state = dcs_pkg::S_IDLE;
        n.irq   = 1'b1;
      end
    end

    // a new command overrides everything else in its cycle
    if (host_i.wr && host_i.addr == dcs_pkg::A_CMD && !r.busy) begin
      n.irq       = 1'b0;
      n.dreq      = 1'b0;
      n.cmd       = host_i.wdata;
      n.errreg    = '0;
      n.err       = 1'b0;
      n.hist      = '0;
      n.ar_used   = 1'b0;
      n.autor     = 1'b0;
      n.bptr      = '0;
      n.po.step   = 1'b0;
      unique case (host_i.wdata[dcs_pkg::OP_MSB:dcs_pkg::OP_LSB])
        dcs_pkg::OP_RESTORE: begin
          n.busy   = 1'b1;
          n.cyl_lo = '0;
          n.cyl_hi = '0;
          n.rate   = host_i.wdata[3:0];
          n.state  = dcs_pkg::S_CHECK;
        end
        dcs_pkg::OP_SEEK: begin
          n.busy  = 1'b1;
          n.rate  = host_i.wdata[3:0];
          n.state = dcs_pkg::S_CHECK;
        end
        dcs_pkg::OP_READ: begin
          n.busy  = 1'b1;
          n.state = dcs_pkg::S_CHECK;
        end
        dcs_pkg::OP_WRITE, dcs_pkg::OP_FORMAT: begin
          n.state = dcs_pkg::S_FILL;
        end
        default: n.state = dcs_pkg::S_IDLE;
      endcase
    end

    n.po.dsel = 4'h1 << n.sdh[dcs_pkg::SDH_DRV_MSB:dcs_pkg::SDH_DRV_LSB];
    n.po.head = n.sdh[dcs_pkg::SDH_HD_MSB:dcs_pkg::SDH_HD_LSB];
    n.po.reduce_current = n.po.write_gate &&
                          ({n.cyl_hi[1:0], n.cyl_lo} >= {n.precomp, 2'b00});
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r         <= '0;
      r.state   <= dcs_pkg::S_IDLE;
      r.rate    <= dcs_pkg::RATE_RST;
      r.precomp <= dcs_pkg::PRECOMP_RST;
      r.scount  <= dcs_pkg::SCOUNT_RST;
      r.irq     <= 1'b1;
      r.po.dsel <= 4'h1;
    end else begin
      r <= n;
    end
  end

  // read address looks one cycle ahead so q tracks the pointer
  dcs_sector_ram u_buf (
    .clk_i   (clk_i),
    .we_i    (ram_we),
    .waddr_i (ram_waddr),
    .wdata_i (ram_wdata),
    .raddr_i (n.bptr),
    .rdata_o (q)
  );

  assign host_rdata_o            = r.rdata;
  assign interrupt_request_out_o = r.irq;
  assign data_request_out_o      = r.dreq;
  assign drv_o                   = r.po;
  assign chan_o                  = r.co;
endmodule

// ### bench/dcs_assertions.sv
// port checker for the disk command sequencer
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ps
module dcs_checker (
  input wire logic                   clk_i,
  input wire logic                   arst_n_i,
  input wire dcs_pkg::dcs_host_s     host_i,
  input wire logic [7:0]             host_rdata_o,
  input wire logic                   interrupt_request_out_o,
  input wire logic                   data_request_out_o,
  input wire dcs_pkg::dcs_drv_out_s  drv_o,
  input wire dcs_pkg::dcs_chan_out_s chan_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_RDATA_IDLE: assert property (!$past(host_i.rd) |-> host_rdata_o == 8'h00)
    else $error("read data outside read slot");
  AST_CMD_CLR_IRQ: assert property (host_i.wr && host_i.addr == dcs_pkg::A_CMD
    |=> !interrupt_request_out_o) else $error("command left interrupt up");
  AST_DATA_CLR_DREQ: assert property ((host_i.wr || host_i.rd)
    && host_i.addr == dcs_pkg::A_DATA |=> !data_request_out_o) else $error("dreq kept");
  AST_STEP_WIDTH: assert property ($rose(drv_o.step)
    |-> ##24 drv_o.step ##1 !drv_o.step) else $error("step width wrong");
  AST_DIR_HOLD: assert property (drv_o.step && $past(drv_o.step)
    |-> $stable(drv_o.dir_out)) else $error("direction moved in step");
  AST_GATE_NO_STEP: assert property (drv_o.write_gate |-> !drv_o.step)
    else $error("stepping while writing");
  AST_SEARCH_NO_STEP: assert property (chan_o.search |-> !drv_o.step)
    else $error("search while stepping");
  AST_SEARCH_GAP: assert property (chan_o.search |=> !chan_o.search)
    else $error("searches too close");
  AST_DSEL_ONEHOT: assert property ($onehot(drv_o.dsel))
    else $error("drive select not one-hot");
  cover property ($rose(drv_o.step));
  cover property ($rose(drv_o.write_gate));
  cover property ($rose(interrupt_request_out_o));
endmodule

bind dcs_sequencer dcs_checker u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .host_i(host_i),
  .host_rdata_o(host_rdata_o), .interrupt_request_out_o(interrupt_request_out_o),
  .data_request_out_o(data_request_out_o), .drv_o(drv_o), .chan_o(chan_o));

// ### bench/dcs_drive_model.sv
// drive model: head position, track zero and status pins
// assumes one drive; the head starts three cylinders in
`timescale 1ns/1ps
module dcs_drive_model (
  input  wire logic                  clk_i,
  input  wire logic                  fault_i,
  input  wire dcs_pkg::dcs_drv_out_s drv_o_i,
  output dcs_pkg::dcs_drv_in_s       drv_i_o
);
  int   pos    = 3;
  logic step_q = 1'b0;
  always @(posedge clk_i) begin
    step_q <= drv_o_i.step;
    if (drv_o_i.step && !step_q) begin
      pos <= drv_o_i.dir_out ? pos - 1 : pos + 1;
    end
  end
  // always ready, so only the fault pin can make a command refused
  assign drv_i_o = '{seek_done: 1'b1, ready: 1'b1, write_fault: fault_i,
                     track_zero_input: pos == 0, index: 1'b0};
endmodule

// ### bench/dcs_sequencer_tb.sv
// self-checking bench for the disk command sequencer
// assumes the channel finds every sector at the first search
`timescale 1ns/1ps
module dcs_sequencer_tb;
  logic                   clk_i    = 1'b0;
  logic                   arst_n_i = 1'b0;
  logic                   fault    = 1'b0;
  dcs_pkg::dcs_host_s     host     = '0;
  dcs_pkg::dcs_chan_in_s  chan     = '0;
  dcs_pkg::dcs_drv_in_s   drv_in;
  dcs_pkg::dcs_drv_out_s  drv_out;
  dcs_pkg::dcs_chan_out_s chan_out;
  logic [7:0]             rdata;
  logic                   irq;
  logic                   dreq;
  logic                   step_d   = 1'b0;
  logic                   dir_seen = 1'b0;
  logic [7:0]             d;
  int                     errors     = 0;
  int                     num_checks = 0;
  int                     steps      = 0;
  int                     wbytes     = 0;
  int                     wbad       = 0;
  int                     s0;
  dcs_sequencer #(.STEP_UNIT_CYC(4)) u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .host_i(host),
    .host_rdata_o(rdata), .interrupt_request_out_o(irq), .data_request_out_o(dreq),
    .drv_i(drv_in), .drv_o(drv_out), .chan_i(chan), .chan_o(chan_out));
  dcs_drive_model u_drive (.clk_i(clk_i), .fault_i(fault), .drv_o_i(drv_out), .drv_i_o(drv_in));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    chan.res_v <= chan_out.search;
    step_d     <= drv_out.step;
    wbytes     <= wbytes + int'(chan_out.wbyte_v);
    // byte k of the sector must leave as value k, under write gate
    if (chan_out.wbyte_v && (chan_out.wbyte != 8'(wbytes) || !drv_out.write_gate)) begin
      wbad <= wbad + 1;
    end
    if (drv_out.step && !step_d) begin
      steps    <= steps + 1;
      dir_seen <= drv_out.dir_out;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    host <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge clk_i);
    host <= '0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [2:0] a);
    host <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    host <= '0;
    @(negedge clk_i);
    d = rdata;
    @(posedge clk_i);
  endtask
  task automatic wait_irq();
    for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(negedge clk_i);
    chk({7'h00, irq}, 8'h01);
    @(posedge clk_i);
  endtask
  task automatic test_reset();
    @(negedge clk_i);
    chk({3'h0, irq, drv_out.dsel}, 8'h11);
    @(posedge clk_i);
    rd(dcs_pkg::A_CMD);
    chk(d, 8'h50);
    chk({7'h00, irq}, 8'h00);
    $display("reset test done");
  endtask
  task automatic test_restore();
    wr(dcs_pkg::A_CYL_LO, 8'h05);
    wr(dcs_pkg::A_CYL_HI, 8'h01);
    s0 = steps;
    wr(dcs_pkg::A_CMD, 8'h10);
    wait_irq();
    chk(8'(steps - s0), 8'h03);
    chk({7'h00, dir_seen}, 8'h01);
    rd(dcs_pkg::A_CYL_LO);
    chk(d, 8'h00);
    rd(dcs_pkg::A_CYL_HI);
    chk(d, 8'h00);
    rd(dcs_pkg::A_CMD);
    chk(d, 8'h50);
    $display("restore test done");
  endtask
  task automatic test_seek();
    wr(dcs_pkg::A_CYL_LO, 8'h02);
    s0 = steps;
    wr(dcs_pkg::A_CMD, 8'h7f);
    wait_irq();
    chk(8'(steps - s0), 8'h02);
    chk({7'h00, dir_seen}, 8'h00);
    rd(dcs_pkg::A_CMD);
    $display("seek test done");
  endtask
  task automatic test_fault();
    fault <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr(dcs_pkg::A_CMD, 8'h10);
    wait_irq();
    rd(dcs_pkg::A_ERROR);
    chk(d, 8'h04);
    rd(dcs_pkg::A_CMD);
    chk(d, 8'h71);
    fault <= 1'b0;
    repeat (4) @(posedge clk_i);
    $display("fault test done");
  endtask
  task automatic test_write();
    wr(dcs_pkg::A_SDH, 8'h60);
    wr(dcs_pkg::A_CYL_LO, 8'h04);
    s0 = steps;
    wr(dcs_pkg::A_CMD, 8'h30);
    rd(dcs_pkg::A_CMD);
    chk(d, 8'h58);
    for (int i = 0; i < 128; i++) begin
      @(negedge clk_i);
      chk({7'h00, dreq}, 8'h01);
      @(posedge clk_i);
      wr(dcs_pkg::A_DATA, 8'(i));
    end
    wait_irq();
    rd(dcs_pkg::A_ERROR);
    chk(d, 8'h00);
    chk(8'(wbytes), 8'h80);
    chk(8'(wbad), 8'h00);
    chk(8'(steps - s0), 8'h02);
    $display("write test done");
  endtask
  task automatic test_read();
    wr(dcs_pkg::A_CMD, 8'h20);
    wait_irq();
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_i);
      chk({7'h00, dreq}, 8'h01);
      @(posedge clk_i);
      rd(dcs_pkg::A_DATA);
      chk(d, 8'(i));
    end
    rd(dcs_pkg::A_CYL_LO);
    rd(dcs_pkg::A_CMD);
    chk(d, 8'h50);
    $display("read test done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #400_000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    test_reset();
    test_restore();
    test_seek();
    test_fault();
    test_write();
    test_read();
    report_and_stop();
  end
endmodule
